// ---- verilog/mad_defs.vh ----
`ifndef MAD_DEFS_VH
`define MAD_DEFS_VH
// Register byte offsets
`define MAD_CTRL_ADDR 12'h000
`define MAD_ACT_THR_ADDR 12'h004
`define MAD_ACT_TIME_ADDR 12'h008
`define MAD_INACT_THR_ADDR 12'h00c
`define MAD_INACT_TIME_ADDR 12'h010
`define MAD_STATUS_ADDR 12'h014
`define MAD_REF_X_ADDR 12'h018
`define MAD_REF_Y_ADDR 12'h01c
`define MAD_REF_Z_ADDR 12'h020
// Control fields
`define MAD_CTRL_ACT_EN 0
`define MAD_CTRL_ACT_REF 1
`define MAD_CTRL_INACT_EN 2
`define MAD_CTRL_INACT_REF 3
`define MAD_CTRL_LINK 4
`define MAD_CTRL_MEAS 5
`define MAD_CTRL_WAKEUP 6
`define MAD_CTRL_BW 7
`define MAD_CTRL_NOISE_LO 8
`define MAD_CTRL_NOISE_HI 9
`define MAD_CTRL_ACT_INT 10
`define MAD_CTRL_INACT_INT 11
`define MAD_CTRL_RESET 12'h080
// Status fields
`define MAD_ST_ACT 0
`define MAD_ST_INACT 1
`define MAD_ST_AWAKE 2
// Noise mode encodings
`define MAD_NOISE_NORMAL 2'h0
`define MAD_NOISE_LOW 2'h1
`define MAD_NOISE_ULTRA 2'h2
// Timing
`define MAD_CLK_HZ 20000000
`define MAD_WAKE_RATE_HZ 6
// Clock over wake-up rate, sized to the divider's 24-bit count
`define MAD_WAKE_DIV 24'd3333333
`define MAD_ACT_TIME_RST 8'h00
`define MAD_INACT_TIME_RST 16'h0000
`endif

// ---- verilog/mad_wake_div.v ----
`default_nettype none
module mad_wake_div #(
  parameter [23:0] DIV = 24'd3333333
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Control
  input wire run_i,
  // Tick
  output wire tick_o
);
  reg [23:0] cnt_q;
  assign tick_o = run_i && (cnt_q == DIV - 24'd1);
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_q <= 24'h000000;
    else if (!run_i || tick_o)
      cnt_q <= 24'h000000;
    else
      cnt_q <= cnt_q + 24'd1;
  end
endmodule
`default_nettype wire

// ---- verilog/mad_axis_cmp.v ----
`default_nettype none
module mad_axis_cmp (
  // Sample and reference
  input wire signed [11:0] sample_i,
  input wire signed [11:0] ref_i,
  // Configuration
  input wire use_ref_i,
  input wire [11:0] act_thr_i,
  input wire [11:0] inact_thr_i,
  // Results
  output wire over_o,
  output wire under_o
);
  wire signed [12:0] diff;
  wire [12:0] mag;
  // Absolute mode uses the raw magnitude, no reference
  assign diff = use_ref_i ? ({sample_i[11], sample_i} - {ref_i[11], ref_i}) : {sample_i[11], sample_i};
  assign mag = diff[12] ? (13'h0000 - diff) : diff;
  assign over_o = mag > {1'b0, act_thr_i};
  assign under_o = mag < {1'b0, inact_thr_i};
endmodule
`default_nettype wire

// ---- verilog/mad_top.v ----
// Functional notes
// - Samples come at output rate; filter bandwidth selects half or quarter rate.
// - Bandwidth select resets to quarter of output rate.
// - Noise mode selects normal, low noise or ultralow noise.
// - Activity only when above threshold for the programmed duration.
// - Absolute activity compares sample directly against threshold.
// - Referenced activity compares magnitude of sample minus reference.
// - Reference captured on enable, after inactivity when linked, after activity unlinked.
// - Activity duration programmable from one sample upward; threshold programmable.
// - Activity timer in measurement mode only; wake-up mode uses one sample.
// - Absolute inactivity needs programmed count of consecutive samples below threshold.
// - Referenced inactivity uses magnitude of sample minus reference below threshold.
// - Inactivity timer counts samples, one up to 65535.
// - Inactivity only after full uninterrupted period; motion restarts it.
// - Each event sets a status flag and optionally an interrupt output.
// - Awake bit shows whether last detection was activity or inactivity.
// - Detection works in measurement mode and wake-up mode.
// - Linked mode arms only one detector, swapping after each event.
// - Wake-up mode samples about six times per second.
//
// Design decisions made here: the placing of the registers and register access over APB.
`include "mad_defs.vh"
`default_nettype none
module mad_top (
  // Clock and reset
  input wire clock_i,
  input wire arst_n_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Sample input at output data rate
  input wire sample_valid_i,
  input wire [11:0] x_i,
  input wire [11:0] y_i,
  input wire [11:0] z_i,
  // Analog front-end control
  output wire filter_bandwidth_select_o,
  output wire [1:0] noise_mode_o,
  output wire sample_req_o,
  // Events
  output wire act_int_o,
  output wire inact_int_o,
  output wire awake_o
);
  reg rst_s1_q;
  reg rst_n_q;
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  reg [11:0] ctrl_q;
  reg [11:0] act_thr_q;
  reg [7:0] act_time_q;
  reg [11:0] inact_thr_q;
  reg [15:0] inact_time_q;
  reg act_flag_q;
  reg inact_flag_q;
  reg awake_q;
  reg [11:0] ref_x_q;
  reg [11:0] ref_y_q;
  reg [11:0] ref_z_q;
  reg [7:0] act_cnt_q;
  reg [15:0] inact_cnt_q;
  reg arm_act_q;
  reg act_en_q;
  reg [31:0] prdata_q;

  function sel_hit;
    input [11:0] addr;
    input [11:0] target;
    begin
      sel_hit = (addr == target);
    end
  endfunction

  wire acc_w = psel_i && penable_i;
  wire wr = acc_w && pwrite_i;
  wire rd_setup = psel_i && !penable_i && !pwrite_i;
  wire mapped = sel_hit(paddr_i, `MAD_CTRL_ADDR) || sel_hit(paddr_i, `MAD_ACT_THR_ADDR) ||
    sel_hit(paddr_i, `MAD_ACT_TIME_ADDR) || sel_hit(paddr_i, `MAD_INACT_THR_ADDR) ||
    sel_hit(paddr_i, `MAD_INACT_TIME_ADDR) || sel_hit(paddr_i, `MAD_STATUS_ADDR) ||
    sel_hit(paddr_i, `MAD_REF_X_ADDR) || sel_hit(paddr_i, `MAD_REF_Y_ADDR) ||
    sel_hit(paddr_i, `MAD_REF_Z_ADDR);
  assign pready_o = 1'b1;
  assign pslverr_o = acc_w && !mapped;
  assign prdata_o = prdata_q;

  wire meas = ctrl_q[`MAD_CTRL_MEAS];
  wire wakeup = ctrl_q[`MAD_CTRL_WAKEUP];
  wire link = ctrl_q[`MAD_CTRL_LINK];
  // Wake-up rate comes from a divider, measurement from the converter's own valid
  wire wake_tick;
  mad_wake_div #(
    .DIV(`MAD_WAKE_DIV)
  ) u_div (
    .clock_i(clock_i),
    .rst_n_i(rst_n_q),
    .run_i(wakeup && !meas),
    .tick_o(wake_tick)
  );
  assign sample_req_o = wake_tick;
  wire running = meas || wakeup;
  wire smp = sample_valid_i && running;

  assign filter_bandwidth_select_o = ctrl_q[`MAD_CTRL_BW];
  assign noise_mode_o = {ctrl_q[`MAD_CTRL_NOISE_HI], ctrl_q[`MAD_CTRL_NOISE_LO]};

  wire [2:0] over_a;
  wire [2:0] under_a;
  wire [2:0] und_i;
  wire [35:0] smp_v = {z_i, y_i, x_i};
  wire [35:0] ref_v = {ref_z_q, ref_y_q, ref_x_q};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_axis
      mad_axis_cmp u_act (
        .sample_i(smp_v[g*12 +: 12]),
        .ref_i(ref_v[g*12 +: 12]),
        .use_ref_i(ctrl_q[`MAD_CTRL_ACT_REF]),
        .act_thr_i(act_thr_q),
        .inact_thr_i(inact_thr_q),
        .over_o(over_a[g]),
        .under_o()
      );
      mad_axis_cmp u_inact (
        .sample_i(smp_v[g*12 +: 12]),
        .ref_i(ref_v[g*12 +: 12]),
        .use_ref_i(ctrl_q[`MAD_CTRL_INACT_REF]),
        .act_thr_i(act_thr_q),
        .inact_thr_i(inact_thr_q),
        .over_o(),
        .under_o(under_a[g])
      );
    end
  endgenerate
  assign und_i = under_a;
  wire act_hit = |over_a;
  wire inact_hit = &und_i;

  // Linked mode arms one detector at a time
  wire act_armed = ctrl_q[`MAD_CTRL_ACT_EN] && (!link || arm_act_q);
  wire inact_armed = ctrl_q[`MAD_CTRL_INACT_EN] && (!link || !arm_act_q);
  // Wake-up mode ignores the activity timer
  wire [7:0] act_need = (meas && act_time_q != 8'h00) ? act_time_q : 8'h01;
  wire [15:0] inact_need = (inact_time_q == 16'h0000) ? 16'h0001 : inact_time_q;
  wire act_ev = smp && act_armed && act_hit && (act_cnt_q + 8'h01 >= act_need);
  wire inact_ev = smp && inact_armed && inact_hit && (inact_cnt_q + 16'h0001 >= inact_need);
  wire act_on = ctrl_q[`MAD_CTRL_ACT_EN] && running;
  wire ref_cap = (act_on && !act_en_q) || (inact_ev && link) || (act_ev && !link);
  wire clr_st = acc_w && !pwrite_i && sel_hit(paddr_i, `MAD_STATUS_ADDR);

  always @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_q <= `MAD_CTRL_RESET;
      act_thr_q <= 12'h000;
      act_time_q <= `MAD_ACT_TIME_RST;
      inact_thr_q <= 12'h000;
      inact_time_q <= `MAD_INACT_TIME_RST;
    end
    else if (wr)
    begin
      if (sel_hit(paddr_i, `MAD_CTRL_ADDR))
        ctrl_q <= pwdata_i[11:0];
      if (sel_hit(paddr_i, `MAD_ACT_THR_ADDR))
        act_thr_q <= pwdata_i[11:0];
      if (sel_hit(paddr_i, `MAD_ACT_TIME_ADDR))
        act_time_q <= pwdata_i[7:0];
      if (sel_hit(paddr_i, `MAD_INACT_THR_ADDR))
        inact_thr_q <= pwdata_i[11:0];
      if (sel_hit(paddr_i, `MAD_INACT_TIME_ADDR))
        inact_time_q <= pwdata_i[15:0];
    end
  end

  always @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      act_cnt_q <= 8'h00;
      inact_cnt_q <= 16'h0000;
      act_flag_q <= 1'b0;
      inact_flag_q <= 1'b0;
      awake_q <= 1'b0;
      arm_act_q <= 1'b1;
      act_en_q <= 1'b0;
      ref_x_q <= 12'h000;
      ref_y_q <= 12'h000;
      ref_z_q <= 12'h000;
    end
    else
    begin
      act_en_q <= act_on;
      if (!act_armed || (smp && (!act_hit || act_ev)))
        act_cnt_q <= 8'h00;
      else if (smp && act_cnt_q != 8'hff)
        act_cnt_q <= act_cnt_q + 8'h01;
      if (!inact_armed || (smp && (!inact_hit || inact_ev)))
        inact_cnt_q <= 16'h0000;
      else if (smp && inact_cnt_q != 16'hffff)
        inact_cnt_q <= inact_cnt_q + 16'h0001;
      // Set wins over a read-clear in the same cycle
      // Clear only what the read reported, so an event at the setup edge survives
      if (act_ev)
        act_flag_q <= 1'b1;
      else if (clr_st && prdata_q[`MAD_ST_ACT])
        act_flag_q <= 1'b0;
      if (inact_ev)
        inact_flag_q <= 1'b1;
      else if (clr_st && prdata_q[`MAD_ST_INACT])
        inact_flag_q <= 1'b0;
      if (act_ev)
        awake_q <= 1'b1;
      else if (inact_ev)
        awake_q <= 1'b0;
      if (act_ev && link)
        arm_act_q <= 1'b0;
      else if (inact_ev && link)
        arm_act_q <= 1'b1;
      if (ref_cap)
      begin
        ref_x_q <= x_i;
        ref_y_q <= y_i;
        ref_z_q <= z_i;
      end
    end
  end

  always @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      prdata_q <= 32'h00000000;
    else if (rd_setup)
    begin
      prdata_q <= 32'h00000000;
      if (sel_hit(paddr_i, `MAD_CTRL_ADDR))
        prdata_q <= {20'h00000, ctrl_q};
      if (sel_hit(paddr_i, `MAD_ACT_THR_ADDR))
        prdata_q <= {20'h00000, act_thr_q};
      if (sel_hit(paddr_i, `MAD_ACT_TIME_ADDR))
        prdata_q <= {24'h000000, act_time_q};
      if (sel_hit(paddr_i, `MAD_INACT_THR_ADDR))
        prdata_q <= {20'h00000, inact_thr_q};
      if (sel_hit(paddr_i, `MAD_INACT_TIME_ADDR))
        prdata_q <= {16'h0000, inact_time_q};
      if (sel_hit(paddr_i, `MAD_STATUS_ADDR))
        prdata_q <= {29'h00000000, awake_q, inact_flag_q, act_flag_q};
      if (sel_hit(paddr_i, `MAD_REF_X_ADDR))
        prdata_q <= {20'h00000, ref_x_q};
      if (sel_hit(paddr_i, `MAD_REF_Y_ADDR))
        prdata_q <= {20'h00000, ref_y_q};
      if (sel_hit(paddr_i, `MAD_REF_Z_ADDR))
        prdata_q <= {20'h00000, ref_z_q};
    end
  end

  assign act_int_o = act_flag_q && ctrl_q[`MAD_CTRL_ACT_INT];
  assign inact_int_o = inact_flag_q && ctrl_q[`MAD_CTRL_INACT_INT];
  assign awake_o = awake_q;
endmodule
`default_nettype wire

// ---- tb/mad_top_checker.sv ----
`default_nettype none
module mad_top_checker (
  // Clock and bus
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pslverr_o,
  // Samples and events
  input wire logic sample_valid_i,
  input wire logic filter_bandwidth_select_o,
  input wire logic [1:0] noise_mode_o,
  input wire logic act_int_o,
  input wire logic inact_int_o,
  input wire logic awake_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence acc_s;
    psel_i && penable_i;
  endsequence
  sequence ctrl_wr_s;
    acc_s ##0 (pwrite_i && paddr_i == 12'h000);
  endsequence
  // A status read racing a sample may legally keep a flag
  sequence stat_rd_s;
    acc_s ##0 (!pwrite_i && paddr_i == 12'h014 && !sample_valid_i && !$past(sample_valid_i));
  endsequence
  err_unmapped_a: assert property (acc_s ##0 (paddr_i > 12'h020 || paddr_i[1:0] != 2'b00) |-> pslverr_o)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (acc_s ##0 (paddr_i <= 12'h020 && paddr_i[1:0] == 2'b00) |-> !pslverr_o)
    else $error("mapped access refused");
  bw_follow_a: assert property (ctrl_wr_s |=> filter_bandwidth_select_o == $past(pwdata_i[7]))
    else $error("bandwidth select wrong");
  noise_follow_a: assert property (ctrl_wr_s |=> noise_mode_o == $past(pwdata_i[9:8]))
    else $error("noise mode wrong");
  // An interrupt enable written over a pending flag also raises the output
  act_on_sample_a: assert property ($rose(act_int_o) && !$past(penable_i) |-> $past(sample_valid_i) && awake_o)
    else $error("activity without sample");
  inact_on_sample_a: assert property ($rose(inact_int_o) && !$past(penable_i) |-> $past(sample_valid_i) && !awake_o)
    else $error("inactivity without sample");
  awake_sample_a: assert property ($changed(awake_o) |-> $past(sample_valid_i))
    else $error("awake moved without sample");
  stat_clear_a: assert property (stat_rd_s |=> !act_int_o && !inact_int_o)
    else $error("status read kept a flag");
endmodule
bind mad_top mad_top_checker u_chk (
  .clock_i(clock_i),
  .arst_n_i(arst_n_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .pslverr_o(pslverr_o),
  .sample_valid_i(sample_valid_i),
  .filter_bandwidth_select_o(filter_bandwidth_select_o),
  .noise_mode_o(noise_mode_o),
  .act_int_o(act_int_o),
  .inact_int_o(inact_int_o),
  .awake_o(awake_o)
);
`default_nettype wire

// ---- tb/mad_host.sv ----
`default_nettype none
module mad_host (
  // Clock and answer
  input wire logic clock_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  // Request
  output var logic psel_o = 1'b0,
  output var logic penable_o = 1'b0,
  output var logic pwrite_o = 1'b0,
  output var logic [11:0] paddr_o = 12'h000,
  output var logic [31:0] pwdata_o = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Called just after a rising edge; returns one edge after release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clock_i);
    penable_o <= 1'b1;
    @(posedge clock_i);
    while (pready_i !== 1'b1) @(posedge clock_i);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_motion_activity_detector.sv ----
`default_nettype none
module tb_motion_activity_detector;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic sv = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, bw, ai, ii, awk_o, e, req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] nm;
  logic [11:0] ax [3] = '{12'h000, 12'h000, 12'h000};
  int n_errors = 0;
  int checks_done = 0;
  int seed = 32'hdb34;
  int ctl = 32'h080;
  int atim, itim, ac, ic;
  int rf [3];
  int cfg [4] = '{32'hc25, 32'hc2f, 32'hc45, 32'hc3f};
  bit af, inf, awk, aa, ia;
  bit arm = 1'b1;
  always #25 clock_i = ~clock_i;
  mad_top dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .sample_valid_i(sv), .x_i(ax[0]), .y_i(ax[1]), .z_i(ax[2]), .filter_bandwidth_select_o(bw),
    .noise_mode_o(nm), .sample_req_o(req), .act_int_o(ai), .inact_int_o(ii), .awake_o(awk_o));
  mad_host host (.clock_i(clock_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    host.xfer(1'b1, a, d, r, e);
    if (a == 12'h000)
    begin
      if (d[0] && d[6:5] != 0 && !(ctl[0] && ctl[6:5] != 0))
        foreach (rf[i]) rf[i] = $signed(ax[i]);
      ctl = d;
      ac = 0;
      ic = 0;
    end
  endtask
  task automatic rd(input logic [11:0] a, input int x);
    host.xfer(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(e, a > 12'h020);
  endtask
  // Absolute magnitudes sit clear of both thresholds; signs are random
  task automatic smp;
    int ov, un, m, a;
    int v [3];
    ov = 0;
    un = 1;
    for (int i = 0; i < 3; i++)
    begin
      v[i] = ($random(seed) & 1) ? 150 + ($random(seed) & 63) : $random(seed) & 31;
      if ($random(seed) & 1)
        v[i] = -v[i];
      ax[i] <= v[i][11:0];
      a = v[i] < 0 ? -v[i] : v[i];
      m = v[i] - rf[i];
      m = m < 0 ? -m : m;
      if ((ctl[1] ? m : a) > 120) ov = 1;
      if ((ctl[3] ? m : a) >= 40) un = 0;
    end
    sv <= 1'b1;
    @(posedge clock_i);
    sv <= 1'b0;
    aa = ctl[0] && (!ctl[4] || arm);
    ia = ctl[2] && (!ctl[4] || !arm);
    ac = aa && ov ? ac + 1 : 0;
    ic = ia && un ? ic + 1 : 0;
    if (aa && ac >= (ctl[5] && atim > 1 ? atim : 1))
    begin
      af = 1;
      awk = 1;
      ac = 0;
      if (ctl[4])
        arm = 0;
      else
        rf = v;
    end
    if (ia && ic >= (itim > 1 ? itim : 1))
    begin
      inf = 1;
      awk = 0;
      ic = 0;
      if (ctl[4])
      begin
        arm = 1;
        rf = v;
      end
    end
    @(posedge clock_i);
    chk(req, 1'b0);
    chk(ai, af);
    chk(ii, inf);
    chk(awk_o, awk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(bw, 1'b1);
    rd(12'h000, 32'h080);
    rd(12'h024, 0);
    for (int n = 0; n < 3; n++)
    begin
      wr(12'h000, n << 8);
      chk(nm, n);
      chk(bw, 1'b0);
    end
    foreach (cfg[k])
    begin
      rd(12'h014, {awk, inf, af});
      af = 0;
      inf = 0;
      wr(12'h000, 0);
      atim = $random(seed) & 3;
      itim = $random(seed) & 3;
      wr(12'h004, 120);
      wr(12'h008, atim);
      wr(12'h00c, 40);
      wr(12'h010, itim);
      rd(12'h008, atim);
      rd(12'h010, itim);
      wr(12'h000, cfg[k]);
      repeat (40) smp;
      rd(12'h018, rf[0] & 32'hfff);
      rd(12'h01c, rf[1] & 32'hfff);
      rd(12'h020, rf[2] & 32'hfff);
    end
    rd(12'h014, {awk, inf, af});
    wrap_up;
  end
  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
